// [ccd_comparator_ctrl.sv]
// Comparator control: enable, input routing, polarity, pin output, change flag.
// Assumes the analog core delivers a raw compare bit and the CPU uses the plain port.
`timescale 1ns/1ps

// Behaviour
// RULE1 - Comparator on bit powers the analog core; off means disabled
// RULE2 - Negative select chooses channel a when 0, channel b when 1
// RULE3 - Reference select routes internal reference when 1, positive pin when 0
// RULE4 - Result is raw compare, inverted when output invert is set
// RULE5 - Polarity-adjusted result is a read-only bit of control register zero
// RULE6 - Pin driven only with pin enable, comparator on and direction clear
// RULE7 - Pin enable overrides the port latch regardless of comparator on
// RULE8 - Internal result registered each instruction cycle; pin path unlatched
// RULE9 - First latch captures result on each read of control register zero
// RULE10 - Second latch captures result every Q1; XOR of latches is mismatch
// RULE11 - Mismatch persists until register read or result returns
// RULE12 - Writes to control register zero also clear the mismatch
// RULE13 - Change flag set on mismatch rising edge, not its level
// RULE14 - Change detection independent of pin enable
// RULE15 - Software clears flag by writing 0; writing 1 sets it
// RULE16 - Flag always set; interrupt needs all three enables
// RULE17 - Change during a read at Q2 start may lose the flag
// RULE18 - Software waits bias settle time before enabling interrupts
// RULE19 - Comparator stays active in sleep; change wakes with two enables
// RULE20 - Reset returns control registers to reset values, comparator off
// RULE21 - Gate select 0 gives comparator result as timer count gate
// RULE22 - Software sets sync when comparator gates the timer
// RULE23 - With sync set, result latched on falling edge of timer clock
// RULE24 - Gate select 1 chooses the external gate pin
// RULE25 - Analog comparison is a single raw input bit
module ccd_comparator_ctrl
  import ccd_pkg::*;
#(
  parameter int ADDR_W = 3
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic raw_compare_i,
  input wire logic pin_direction_i,
  input wire logic port_latch_i,
  input wire logic timer_clk_i,
  input wire logic ext_gate_i,
  output logic comparator_on_o,
  output logic neg_input_select_o,
  output logic pos_ref_select_o,
  output logic hysteresis_o,
  output logic alt_clock_o,
  output logic pin_o,
  output logic pin_oe_n_o,
  output logic timer_gate_o,
  output logic irq_o,
  output logic wake_o
);

  if (ADDR_W < 3) begin : g_bad_addr_w
    $error("ADDR_W must be at least 3");
  end

  // ==========================================================
  // Input synchronisers
  logic [1:0] raw_sync_ff;
  logic [1:0] dir_sync_ff;
  logic [1:0] latch_sync_ff;
  logic [1:0] tclk_sync_ff;
  logic [1:0] gate_sync_ff;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      raw_sync_ff <= 2'h0;
      dir_sync_ff <= 2'h3;
      latch_sync_ff <= 2'h0;
      tclk_sync_ff <= 2'h0;
      gate_sync_ff <= 2'h0;
    end else if (ce_i) begin
      raw_sync_ff <= {raw_sync_ff[0], raw_compare_i};
      dir_sync_ff <= {dir_sync_ff[0], pin_direction_i};
      latch_sync_ff <= {latch_sync_ff[0], port_latch_i};
      tclk_sync_ff <= {tclk_sync_ff[0], timer_clk_i};
      gate_sync_ff <= {gate_sync_ff[0], ext_gate_i};
    end
  end

  // ==========================================================
  // Register decode
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [2:0] idx);
    return addr == ADDR_W'(idx);
  endfunction

  logic sel_c0;
  logic sel_c1;
  logic sel_fl;
  logic sel_en;
  assign sel_c0 = addr_hit(reg_addr_i, CCD_ADDR_CTRL0);
  assign sel_c1 = addr_hit(reg_addr_i, CCD_ADDR_CTRL1);
  assign sel_fl = addr_hit(reg_addr_i, CCD_ADDR_FLAG);
  assign sel_en = addr_hit(reg_addr_i, CCD_ADDR_IRQEN);

  logic [7:0] ctrl0_ff;
  logic [7:0] ctrl1_ff;
  logic [2:0] irq_en_ff;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl0_ff <= CCD_C0_RESET; // RULE20
      ctrl1_ff <= CCD_C1_RESET; // RULE20
      irq_en_ff <= 3'h0;
    end else if (ce_i && reg_wr_i) begin
      if (sel_c0) begin
        ctrl0_ff <= reg_wdata_i & CCD_C0_WMASK;
      end
      if (sel_c1) begin
        ctrl1_ff <= reg_wdata_i & CCD_C1_WMASK;
      end
      if (sel_en) begin
        irq_en_ff <= reg_wdata_i[2:0];
      end
    end
  end

  logic cmp_on;
  logic invert;
  logic pin_en;
  logic gate_sel;
  logic sync_en;
  assign cmp_on = ctrl0_ff[CCD_C0_ON];
  assign invert = ctrl0_ff[CCD_C0_INVERT];
  assign pin_en = ctrl0_ff[CCD_C0_PIN_EN];
  assign gate_sel = ctrl1_ff[CCD_C1_GATE_SEL];
  assign sync_en = ctrl1_ff[CCD_C1_SYNC];

  // ==========================================================
  // Q phase sequencer, one instruction cycle per four clocks
  ccd_phase_t phase_ff;
  ccd_phase_t nxt_phase;

  always_comb begin
    unique case (phase_ff)
      CCD_Q1: nxt_phase = CCD_Q2;
      CCD_Q2: nxt_phase = CCD_Q3;
      CCD_Q3: nxt_phase = CCD_Q4;
      CCD_Q4: nxt_phase = CCD_Q1;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_ff <= CCD_Q1;
    end else if (ce_i) begin
      phase_ff <= nxt_phase;
    end
  end

  // ==========================================================
  // Result path
  logic live_result;
  assign live_result = cmp_on & (raw_sync_ff[1] ^ invert); // RULE1 RULE4 RULE25

  logic result_ff;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      result_ff <= 1'b0;
    end else if (ce_i && phase_ff == CCD_Q4) begin
      result_ff <= live_result; // RULE8
    end
  end

  // ==========================================================
  // Mismatch latches and change flag
  logic read_latch_ff;
  logic q1_latch_ff;
  logic mismatch_ff;
  logic change_flag_ff;
  logic c0_access;
  logic mismatch;
  assign c0_access = ce_i && sel_c0 && (reg_rd_i || reg_wr_i); // RULE12
  assign mismatch = read_latch_ff ^ q1_latch_ff; // RULE10

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      read_latch_ff <= 1'b0;
    end else if (c0_access) begin
      read_latch_ff <= result_ff; // RULE9 RULE11
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q1_latch_ff <= 1'b0;
    end else if (ce_i && phase_ff == CCD_Q1) begin
      q1_latch_ff <= result_ff; // RULE10
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mismatch_ff <= 1'b0;
    end else if (ce_i) begin
      mismatch_ff <= mismatch;
    end
  end

  // Set beats a same-cycle clear; independent of pin enable
  logic mismatch_rise;
  assign mismatch_rise = mismatch & ~mismatch_ff; // RULE13 RULE14 RULE17

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      change_flag_ff <= 1'b0;
    end else if (ce_i) begin
      if (mismatch_rise) begin
        change_flag_ff <= 1'b1; // RULE16
      end else if (reg_wr_i && sel_fl) begin
        change_flag_ff <= reg_wdata_i[CCD_FL_CHANGE]; // RULE15
      end
    end
  end

  // ==========================================================
  // Interrupt and wake
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
      wake_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= change_flag_ff & (&irq_en_ff); // RULE16
      wake_o <= change_flag_ff & irq_en_ff[CCD_EN_CHANGE] & irq_en_ff[CCD_EN_PERIPH]; // RULE19
    end
  end

  // ==========================================================
  // Pin output and analog controls
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_o <= 1'b0;
      pin_oe_n_o <= 1'b1;
      comparator_on_o <= 1'b0;
      neg_input_select_o <= 1'b0;
      pos_ref_select_o <= 1'b0;
      hysteresis_o <= 1'b0;
      alt_clock_o <= 1'b0;
    end else if (ce_i) begin
      pin_o <= pin_en ? live_result : latch_sync_ff[1]; // RULE7 RULE8
      pin_oe_n_o <= ~(pin_en & cmp_on & ~dir_sync_ff[1]); // RULE6
      comparator_on_o <= cmp_on; // RULE1 RULE19
      neg_input_select_o <= ctrl0_ff[CCD_C0_NEG]; // RULE2
      pos_ref_select_o <= ctrl0_ff[CCD_C0_REF]; // RULE3
      hysteresis_o <= ctrl1_ff[CCD_C1_HYST];
      alt_clock_o <= ctrl1_ff[CCD_C1_ALT_CLK];
    end
  end

  // ==========================================================
  // Timer gate source and synchronisation
  logic tclk_prev_ff;
  logic sync_result_ff;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tclk_prev_ff <= 1'b0;
      sync_result_ff <= 1'b0;
      timer_gate_o <= 1'b0;
    end else if (ce_i) begin
      tclk_prev_ff <= tclk_sync_ff[1];
      if (tclk_prev_ff && !tclk_sync_ff[1]) begin
        sync_result_ff <= result_ff; // RULE23
      end
      if (gate_sel) begin
        timer_gate_o <= gate_sync_ff[1]; // RULE24
      end else begin
        timer_gate_o <= sync_en ? sync_result_ff : result_ff; // RULE21 RULE22
      end
    end
  end

  // ==========================================================
  // Read data, one cycle after the strobe
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (ce_i) begin
      if (reg_rd_i) begin
        unique case (1'b1)
          sel_c0: reg_rdata_o <= {ctrl0_ff[7], result_ff, ctrl0_ff[5:0]}; // RULE5
          sel_c1: reg_rdata_o <= ctrl1_ff;
          sel_fl: reg_rdata_o <= {7'h00, change_flag_ff};
          sel_en: reg_rdata_o <= {5'h00, irq_en_ff};
          default: reg_rdata_o <= 8'h00;
        endcase
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  // ==========================================================
  // Checks
  AST_PIN_GATE: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE6
    ce_i && !(pin_en && cmp_on && !dir_sync_ff[1]) |=> pin_oe_n_o)
    else $error("pin driven without all enables");

  AST_FLAG_SET: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE13
    ce_i && mismatch_rise |=> change_flag_ff)
    else $error("change flag missed mismatch edge");

  AST_FLAG_CLR: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE15
    ce_i && reg_wr_i && sel_fl && !reg_wdata_i[0] && !mismatch_rise |=> !change_flag_ff)
    else $error("flag not cleared by write of zero");

  AST_IRQ_EN: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE16
    irq_o |-> $past(change_flag_ff) && $past(irq_en_ff) == 3'h7)
    else $error("interrupt without all enables");

  AST_READ_CLEARS: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE11
    c0_access |=> read_latch_ff == $past(result_ff))
    else $error("read did not capture result");

  AST_Q1_LATCH: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE10
    ce_i && phase_ff == CCD_Q1 |=> q1_latch_ff == $past(result_ff))
    else $error("second latch missed Q1");

  AST_RESULT_HOLD: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE8
    ce_i && phase_ff != CCD_Q4 |=> $stable(result_ff))
    else $error("result changed outside instruction boundary");

  AST_OFF_ZERO: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE1
    ce_i && !cmp_on && phase_ff == CCD_Q4 |=> !result_ff)
    else $error("result high while comparator off");

  AST_READBACK: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE5
    ce_i && reg_rd_i && sel_c0 |=> reg_rdata_o[CCD_C0_RESULT] == $past(result_ff))
    else $error("result bit not reported");

  AST_PIN_DRIVE: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE6
    ce_i && pin_en && cmp_on && !dir_sync_ff[1] |=> !pin_oe_n_o)
    else $error("pin not driven with all enables");

  AST_PIN_RESULT: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE7
    ce_i && pin_en |=> pin_o == $past(live_result))
    else $error("pin enable did not override port latch");

  AST_PIN_LATCH: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE7
    ce_i && !pin_en |=> pin_o == $past(latch_sync_ff[1]))
    else $error("pin did not follow port latch");

  AST_FLAG_WRITE_SET: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE15
    ce_i && reg_wr_i && sel_fl && reg_wdata_i[CCD_FL_CHANGE] |=> change_flag_ff)
    else $error("flag not set by write of one");

  AST_WAKE: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE19
    ce_i |=> wake_o == ($past(change_flag_ff) && $past(irq_en_ff[CCD_EN_CHANGE])
      && $past(irq_en_ff[CCD_EN_PERIPH])))
    else $error("wake does not follow flag and enables");

  AST_GATE_PIN: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE24
    ce_i && gate_sel |=> timer_gate_o == $past(gate_sync_ff[1]))
    else $error("gate does not follow external gate pin");

  AST_GATE_RESULT: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE21
    ce_i && !gate_sel && !sync_en |=> timer_gate_o == $past(result_ff))
    else $error("gate does not follow result");

  AST_GATE_SYNC: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE23
    ce_i && !gate_sel && sync_en |=> timer_gate_o == $past(sync_result_ff))
    else $error("gate does not follow synchronised result");

  AST_SELECT_OUT: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RULE2
    ce_i |=> neg_input_select_o == $past(ctrl0_ff[CCD_C0_NEG])
      && pos_ref_select_o == $past(ctrl0_ff[CCD_C0_REF]))
    else $error("input selects not forwarded");

endmodule

// [ccd_pkg.sv]
// Package for the comparator control and change-detect block.
// Assumes a single 10 MHz clock domain and the plain register port.
package ccd_pkg;

  // ==========================================================
  // Register indices (byte offsets on the plain port)
  localparam logic [2:0] CCD_ADDR_CTRL0 = 3'h0;
  localparam logic [2:0] CCD_ADDR_CTRL1 = 3'h1;
  localparam logic [2:0] CCD_ADDR_FLAG = 3'h2;
  localparam logic [2:0] CCD_ADDR_IRQEN = 3'h3;

  // ==========================================================
  // Field positions, control register zero
  localparam int CCD_C0_ON = 7;
  localparam int CCD_C0_RESULT = 6;
  localparam int CCD_C0_PIN_EN = 5;
  localparam int CCD_C0_INVERT = 4;
  localparam int CCD_C0_REF = 2;
  localparam int CCD_C0_NEG = 0;
  localparam logic [7:0] CCD_C0_WMASK = 8'hB5;

  // Field positions, control register one
  localparam int CCD_C1_ALT_CLK = 4;
  localparam int CCD_C1_HYST = 3;
  localparam int CCD_C1_GATE_SEL = 1;
  localparam int CCD_C1_SYNC = 0;
  localparam logic [7:0] CCD_C1_WMASK = 8'h1B;

  // Field positions, flag and enable registers
  localparam int CCD_FL_CHANGE = 0;
  localparam int CCD_EN_CHANGE = 0;
  localparam int CCD_EN_PERIPH = 1;
  localparam int CCD_EN_GLOBAL = 2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CCD_C0_RESET = 8'h00;
  localparam logic [7:0] CCD_C1_RESET = 8'h00;

  // ==========================================================
  // Timing: four clocks per instruction cycle, bias settle time
  localparam int CCD_CLK_HZ = 10000000;
  localparam int CCD_BIAS_SETTLE_NS = 1000;
  localparam int CCD_BIAS_SETTLE_CYC = (CCD_BIAS_SETTLE_NS * (CCD_CLK_HZ / 1000000) + 999) / 1000;

  typedef enum logic [1:0] {
    CCD_Q1 = 2'b00,
    CCD_Q2 = 2'b01,
    CCD_Q3 = 2'b11,
    CCD_Q4 = 2'b10
  } ccd_phase_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ccd_bus_req_t;

  typedef struct packed {
    logic result;
    logic pin_drive;
    logic pin_oe_n;
    logic gate;
  } ccd_out_t;

endpackage

// [ccd_analog_model.sv]
// Analog comparator core model: picks the input levels and compares them.
// Assumes the testbench supplies input levels as 8-bit codes.
`timescale 1ns/1ps
module ccd_analog_model (
  input wire logic on_i,
  input wire logic neg_sel_i,
  input wire logic ref_sel_i,
  input wire logic [7:0] neg_a_i,
  input wire logic [7:0] neg_b_i,
  input wire logic [7:0] pos_pin_i,
  input wire logic [7:0] ref_i,
  output logic raw_o
);
  logic [7:0] inv_lvl;
  logic [7:0] noninv_lvl;
  assign inv_lvl = neg_sel_i ? neg_b_i : neg_a_i;
  assign noninv_lvl = ref_sel_i ? ref_i : pos_pin_i;
  // Unpowered core gives a low output
  assign raw_o = on_i & (noninv_lvl > inv_lvl);
endmodule

// [ccd_comparator_ctrl_tb_top.sv]
// Testbench for the comparator control block with an analog core model.
// Assumes the plain register port and a 10 MHz clock.
`timescale 1ns/1ps
module ccd_comparator_ctrl_tb_top;
  import ccd_pkg::*;
  logic clk_i, arst_n_i, reg_wr_i, reg_rd_i, raw, pdir, plat, tclk, xgate, rd_seen;
  logic c_on, c_neg, c_ref, hyst, aclk, pin, oe_n, gate, irq, wake, ce;
  logic [2:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, va, vb, vp, vr, c;
  logic [7:0] rdq[$];
  int n_mismatch, samples_checked;

  ccd_comparator_ctrl ccd_comparator_ctrl_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .raw_compare_i(raw), .pin_direction_i(pdir), .port_latch_i(plat), .timer_clk_i(tclk),
    .ext_gate_i(xgate), .comparator_on_o(c_on), .neg_input_select_o(c_neg), .pos_ref_select_o(c_ref),
    .hysteresis_o(hyst), .alt_clock_o(aclk), .pin_o(pin), .pin_oe_n_o(oe_n), .timer_gate_o(gate),
    .irq_o(irq), .wake_o(wake));

  ccd_analog_model ccd_analog_model_inst (
    .on_i(c_on), .neg_sel_i(c_neg), .ref_sel_i(c_ref), .neg_a_i(va), .neg_b_i(vb),
    .pos_pin_i(vp), .ref_i(vr), .raw_o(raw));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ==========================================================
  // Checking
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  always @(posedge clk_i) begin
    if (rd_seen && rdq.size() > 0) begin
      cmp(reg_rdata_o, rdq.pop_front());
    end
    rd_seen <= reg_rd_i;
  end

  function automatic logic res(input logic [7:0] c0);
    logic [7:0] n;
    logic [7:0] p;
    n = c0[CCD_C0_NEG] ? vb : va;
    p = c0[CCD_C0_REF] ? vr : vp;
    return c0[CCD_C0_ON] & ((p > n) ^ c0[CCD_C0_INVERT]);
  endfunction

  task automatic summarize;
    if (rdq.size() != 0) begin
      n_mismatch++;
    end
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Register port
  task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
    reg_wr_i <= w;
    reg_rd_i <= r;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
  endtask

  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 3'h0, 8'h00);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    rdq.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask

  initial begin
    repeat (6000) @(posedge clk_i);
    n_mismatch++;
    summarize();
  end

  // ==========================================================
  // Scenarios
  initial begin
    arst_n_i = 1'b0;
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
    {pdir, plat, tclk, xgate, ce} = 5'b10101;
    {va, vb, vp, vr} = {8'h40, 8'h40, 8'h20, 8'h20};
    n_mismatch = 0;
    samples_checked = 0;
    void'($urandom(99774));
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    cmp({c_on, c_neg, c_ref, hyst, aclk, pin, gate, irq}, 8'h00);
    cmp({6'h00, wake, oe_n}, 8'h01);
    for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
    // Every routing and polarity combination
    for (int i = 0; i < 8; i++) begin
      c = {1'b1, 2'b00, i[2], 1'b0, i[1], 1'b0, i[0]};
      va <= 8'($urandom);
      vb <= 8'($urandom);
      vp <= 8'($urandom);
      vr <= 8'($urandom);
      bus(1'b1, 1'b0, CCD_ADDR_CTRL0, c);
      idle(12);
      cmp({5'h00, c_on, c_neg, c_ref}, {5'h00, 1'b1, i[0], i[1]});
      rd(CCD_ADDR_CTRL0, c & CCD_C0_WMASK | {1'b0, res(c), 6'h00});
    end
    bus(1'b1, 1'b0, CCD_ADDR_CTRL0, 8'h7F);
    idle(12);
    rd(CCD_ADDR_CTRL0, 8'h35);
    // Pin drive conditions
    for (int i = 0; i < 8; i++) begin
      c = {i[1], 1'b0, i[0], 5'h00};
      pdir <= i[2];
      plat <= 1'($urandom);
      bus(1'b1, 1'b0, CCD_ADDR_CTRL0, c);
      idle(8);
      cmp({6'h00, oe_n, pin}, {6'h00, !(i[0] && i[1] && !i[2]), i[0] ? res(c) : plat});
    end
    // Change detection with the pin enabled, then with the pin disabled
    va <= 8'h40;
    vp <= 8'h20;
    pdir <= 1'b0;
    bus(1'b1, 1'b0, CCD_ADDR_CTRL0, 8'hA0);
    idle(CCD_BIAS_SETTLE_CYC);
    rd(CCD_ADDR_CTRL0, 8'hA0);
    bus(1'b1, 1'b0, CCD_ADDR_FLAG, 8'h00);
    bus(1'b1, 1'b0, CCD_ADDR_IRQEN, 8'h07);
    vp <= 8'h60;
    idle(12);
    rd(CCD_ADDR_FLAG, 8'h01);
    cmp({6'h00, irq, wake}, 8'h03);
    bus(1'b1, 1'b0, CCD_ADDR_FLAG, 8'h00);
    idle(12);
    rd(CCD_ADDR_FLAG, 8'h00);
    cmp({6'h00, irq, wake}, 8'h00);
    vp <= 8'h20;
    idle(12);
    rd(CCD_ADDR_FLAG, 8'h00);
    vp <= 8'h60;
    idle(12);
    bus(1'b1, 1'b0, CCD_ADDR_CTRL0, 8'h80);
    bus(1'b1, 1'b0, CCD_ADDR_FLAG, 8'h00);
    vp <= 8'h20;
    idle(12);
    rd(CCD_ADDR_FLAG, 8'h01);
    for (int e = 0; e < 8; e++) begin
      bus(1'b1, 1'b0, CCD_ADDR_IRQEN, 8'(e));
      bus(1'b1, 1'b0, CCD_ADDR_FLAG, 8'h00);
      bus(1'b1, 1'b0, CCD_ADDR_FLAG, 8'h01);
      idle(4);
      cmp({6'h00, irq, wake}, {6'h00, e == 7, e[0] & e[1]});
    end
    // Timer gate sources and sync
    xgate <= 1'b1;
    bus(1'b1, 1'b0, CCD_ADDR_CTRL1, 8'hFE);
    idle(6);
    rd(CCD_ADDR_CTRL1, 8'h1A);
    cmp({5'h00, hyst, aclk, gate}, 8'h07);
    xgate <= 1'b0;
    idle(6);
    cmp({7'h00, gate}, 8'h00);
    bus(1'b1, 1'b0, CCD_ADDR_CTRL1, 8'h00);
    vp <= 8'h60;
    idle(12);
    cmp({7'h00, gate}, 8'h01);
    bus(1'b1, 1'b0, CCD_ADDR_CTRL1, 8'h01);
    tclk <= 1'b0;
    idle(6);
    tclk <= 1'b1;
    vp <= 8'h20;
    idle(12);
    cmp({7'h00, gate}, 8'h01);
    tclk <= 1'b0;
    idle(6);
    cmp({7'h00, gate}, 8'h00);
    // Clock enable low: the enable write must be ignored
    ce <= 1'b0;
    bus(1'b1, 1'b0, CCD_ADDR_IRQEN, 8'h00);
    ce <= 1'b1;
    idle(2);
    cmp({6'h00, irq, wake}, 8'h03);
    idle(2);
    summarize();
  end
endmodule
